// File: hw/bpw_pkg.sv
// Package with register map, field positions and reset values of the port block
package bpw_pkg;
  localparam logic [7:0] BPW_OFF_PA_DATA = 8'h00;
  localparam logic [7:0] BPW_OFF_PA_DIR = 8'h04;
  localparam logic [7:0] BPW_OFF_PA_PU = 8'h08;
  localparam logic [7:0] BPW_OFF_PA_WAKE = 8'h0c;
  localparam logic [7:0] BPW_OFF_PB_DATA = 8'h10;
  localparam logic [7:0] BPW_OFF_PB_DIR = 8'h14;
  localparam logic [7:0] BPW_OFF_PB_PU = 8'h18;
  localparam logic [7:0] BPW_OFF_FN_CTRL = 8'h1c;
  localparam logic [7:0] BPW_OFF_ANALOG = 8'h20;
  localparam logic [7:0] BPW_OFF_HALT = 8'h24;
  localparam logic [7:0] BPW_OFF_IRQ_STAT = 8'h28;
  localparam logic [7:0] BPW_OFF_IRQ_MASK = 8'h2c;

  localparam logic [7:0] BPW_RST_PA_DATA = 8'hff;
  localparam logic [7:0] BPW_RST_PA_DIR = 8'hff;
  localparam logic [7:0] BPW_RST_PA_PU = 8'h00;
  localparam logic [7:0] BPW_RST_PA_WAKE = 8'h00;
  localparam logic [5:0] BPW_RST_PB_DATA = 6'h3f;
  localparam logic [5:0] BPW_RST_PB_DIR = 6'h3f;
  localparam logic [5:0] BPW_RST_PB_PU = 6'h00;
  localparam logic [3:0] BPW_RST_FN_CTRL = 4'h0;
  localparam logic [3:0] BPW_RST_ANALOG = 4'h0;

  // Implemented pull-up bits: port A bit 7 has none
  localparam logic [7:0] BPW_PA_PU_MASK = 8'h7f;

  // Function control fields
  localparam int BPW_FN_FREQ = 0;
  localparam int BPW_FN_PWM = 1;
  localparam int BPW_FN_T0_EXT = 2;
  localparam int BPW_FN_T1_EXT = 3;

  // Shared pin positions
  localparam int BPW_PA_EXT_IRQ = 3;
  localparam int BPW_PA_TIMER0 = 5;
  localparam int BPW_PA_TIMER1 = 6;
  localparam int BPW_PA_OPEN_DRAIN = 7;
  localparam int BPW_PB_PWM = 4;
  localparam int BPW_PB_FREQ_P = 5;
  localparam int BPW_PA_FREQ_N = 4;

  // Interrupt status fields
  localparam int BPW_IRQ_WAKE = 0;
  localparam int BPW_IRQ_EXT = 1;

  typedef enum logic [0:0] {
    BPW_RUN = 1'b0,
    BPW_HALT = 1'b1
  } bpw_pd_t;
endpackage

// File: hw/bpw_port.sv
// Two bidirectional ports with pull-ups, wake-up and shared-pin routing behind APB
//
// How it works
// [R01] Port reads sample live pin levels at the end of the bus setup cycle.
// [R02] Output latches hold written values until the next write to them.
// [R03] Pull-up only on input pins with enable set; port A bit 7 has none.
// [R04] Writing the halt register stops the system clock until a wake event.
// [R05] In power-down a falling edge on a wake-enabled port A pin wakes.
// [R06] Wake enable bit 1 enables its pin's wake-up, 0 disables it.
// [R07] Direction 1 is input, 0 is output of latch, push-pull except open-drain port A bit 7; changes any time.
// [R08] Pull-up enable 1 connects the pull-up, 0 leaves it off.
// [R09] Reading an output pin returns its latch, not the pin level.
// [R10] External interrupt on port A bit 3 needs input direction; reads still work.
// [R11] Timer pins feed timers only in external modes with input direction.
// [R12] Frequency outputs drive their pins only when selected and direction is output.
// [R13] PWM drives its pin only when selected and direction is output.
// [R14] Analog-selected pins lose their pull-up regardless of its enable.
// [R15] After reset all latches and directions are ones, so pins are inputs.
// [R16] Bit set and clear are read-modify-write of the whole port byte.
// [R17] Wake detection works with the clock stopped via an asynchronous set.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module bpw_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  input wire logic [5:0] pb_in,
  output logic [5:0] pb_out,
  output logic [5:0] pb_oe,
  output logic [5:0] pb_pullup,
  input wire logic freq_divider_output,
  input wire logic pwm_in,
  output logic ext_irq_pin,
  output logic timer0_input_pin,
  output logic timer1_input_pin,
  output logic clk_stop,
  output logic wake_req,
  output logic irq
);
  import bpw_pkg::*;

  // Input pins read as live level, output pins as latch
  function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin);
    port_view = (dir & pin) | (~dir & latch);
  endfunction

  logic [7:0] pa_data_q;
  logic [7:0] pa_dir_q;
  logic [7:0] pa_pu_q;
  logic [7:0] pa_wake_q;
  logic [5:0] pb_data_q;
  logic [5:0] pb_dir_q;
  logic [5:0] pb_pu_q;
  logic [3:0] fn_ctrl_q;
  logic [3:0] analog_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  bpw_pd_t pd_q;
  bpw_pd_t pd_d;
  logic [7:0] pa_armed_q;
  logic pa_ext_prev_q;
  logic wake_req_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [7:0] pa_out_q;
  logic [7:0] pa_oe_q;
  logic [7:0] pa_pu_out_q;
  logic [5:0] pb_out_q;
  logic [5:0] pb_oe_q;
  logic [5:0] pb_pu_out_q;
  logic ext_irq_q;
  logic timer0_q;
  logic timer1_q;
  logic irq_q;

  // Bus decode
  // Every register answers in one access cycle, so no wait-state counter is kept
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready_q;
  wire hit_pa_data = paddr == BPW_OFF_PA_DATA;
  wire hit_pa_dir = paddr == BPW_OFF_PA_DIR;
  wire hit_pa_pu = paddr == BPW_OFF_PA_PU;
  wire hit_pa_wake = paddr == BPW_OFF_PA_WAKE;
  wire hit_pb_data = paddr == BPW_OFF_PB_DATA;
  wire hit_pb_dir = paddr == BPW_OFF_PB_DIR;
  wire hit_pb_pu = paddr == BPW_OFF_PB_PU;
  wire hit_fn = paddr == BPW_OFF_FN_CTRL;
  wire hit_analog = paddr == BPW_OFF_ANALOG;
  wire hit_halt = paddr == BPW_OFF_HALT;
  wire hit_stat = paddr == BPW_OFF_IRQ_STAT;
  wire hit_mask = paddr == BPW_OFF_IRQ_MASK;
  wire mapped = hit_pa_data | hit_pa_dir | hit_pa_pu | hit_pa_wake | hit_pb_data |
                hit_pb_dir | hit_pb_pu | hit_fn | hit_analog | hit_halt | hit_stat | hit_mask;
  wire wr_ok = wr_en & mapped;

  wire [7:0] pa_view = port_view(pa_data_q, pa_dir_q, pa_in); // R01 R09
  wire [7:0] pb_view = port_view({2'b00, pb_data_q}, {2'b00, pb_dir_q}, {2'b00, pb_in});

  wire [31:0] rd_mux =
    hit_pa_data ? {24'h000000, pa_view} :
    hit_pa_dir ? {24'h000000, pa_dir_q} :
    hit_pa_pu ? {24'h000000, pa_pu_q} :
    hit_pa_wake ? {24'h000000, pa_wake_q} :
    hit_pb_data ? {24'h000000, pb_view} :
    hit_pb_dir ? {26'h0000000, pb_dir_q} :
    hit_pb_pu ? {26'h0000000, pb_pu_q} :
    hit_fn ? {28'h0000000, fn_ctrl_q} :
    hit_analog ? {28'h0000000, analog_q} :
    hit_halt ? {31'h00000000, pd_q == BPW_HALT} :
    hit_stat ? {30'h00000000, irq_stat_q} :
    hit_mask ? {30'h00000000, irq_mask_q} : 32'h00000000;

  // One wait-free access phase; pins are sampled at the end of setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup & ~pwrite) begin
        prdata_q <= rd_mux; // R01
      end
    end
  end

  // Configuration and latches; software bit operations arrive as full-byte writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_q <= BPW_RST_PA_DATA; // R15
      pa_dir_q <= BPW_RST_PA_DIR; // R15
      pa_pu_q <= BPW_RST_PA_PU;
      pa_wake_q <= BPW_RST_PA_WAKE;
      pb_data_q <= BPW_RST_PB_DATA; // R15
      pb_dir_q <= BPW_RST_PB_DIR; // R15
      pb_pu_q <= BPW_RST_PB_PU;
      fn_ctrl_q <= BPW_RST_FN_CTRL;
      analog_q <= BPW_RST_ANALOG;
      irq_mask_q <= 2'b00;
    end else if (wr_ok) begin
      if (hit_pa_data) pa_data_q <= pwdata[7:0]; // R02 R16
      if (hit_pa_dir) pa_dir_q <= pwdata[7:0]; // R07
      if (hit_pa_pu) pa_pu_q <= pwdata[7:0] & BPW_PA_PU_MASK; // R03
      if (hit_pa_wake) pa_wake_q <= pwdata[7:0]; // R06
      if (hit_pb_data) pb_data_q <= pwdata[5:0]; // R02 R16
      if (hit_pb_dir) pb_dir_q <= pwdata[5:0]; // R07
      if (hit_pb_pu) pb_pu_q <= pwdata[5:0];
      if (hit_fn) fn_ctrl_q <= pwdata[3:0];
      if (hit_analog) analog_q <= pwdata[3:0];
      if (hit_mask) irq_mask_q <= pwdata[1:0];
    end
  end

  // Power-down: the clock stop request holds until the wake flop sets
  wire halt_wr = wr_ok & hit_halt & pwdata[0];
  always_comb begin
    pd_d = pd_q;
    case (pd_q)
      BPW_RUN: begin
        if (halt_wr) pd_d = BPW_HALT; // R04
      end
      BPW_HALT: begin
        if (wake_req_q) pd_d = BPW_RUN;
      end
      default: pd_d = BPW_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_q <= BPW_RUN;
    end else begin
      pd_q <= pd_d;
    end
  end

  // Pins seen high while the clock still ran are armed for a falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_armed_q <= 8'h00;
      // Low at reset, so a pin already low at release raises no false edge
      pa_ext_prev_q <= 1'b0;
    end else begin
      pa_armed_q <= pa_in;
      pa_ext_prev_q <= pa_in[BPW_PA_EXT_IRQ];
    end
  end

  // The clock is stopped, so the edge itself must set the flop without it
  // Limitation: a glitch on an enabled pin while halted wakes the block as well
  wire wake_hit = (pd_q == BPW_HALT) & |(pa_wake_q & pa_armed_q & ~pa_in); // R05 R06

  always_ff @(posedge pclk or negedge presetn or posedge wake_hit) begin
    if (!presetn) begin
      wake_req_q <= 1'b0;
    end else if (wake_hit) begin
      wake_req_q <= 1'b1; // R17
    end else begin
      wake_req_q <= 1'b0;
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle
  wire [1:0] irq_ev;
  assign irq_ev[BPW_IRQ_WAKE] = wake_req_q & (pd_q == BPW_HALT);
  assign irq_ev[BPW_IRQ_EXT] = pa_dir_q[BPW_PA_EXT_IRQ] & pa_ext_prev_q &
                               ~pa_in[BPW_PA_EXT_IRQ];
  wire [1:0] irq_clr = (wr_ok & hit_stat) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'b00;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      irq_q <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_mask_q);
    end
  end

  // Pin drive: output direction drives the latch or a selected shared function
  wire [7:0] pa_func_sel;
  wire [7:0] pa_func_val;
  wire [5:0] pb_func_sel;
  wire [5:0] pb_func_val;
  assign pa_func_sel = {3'b000, fn_ctrl_q[BPW_FN_FREQ], 4'h0};
  assign pa_func_val = {3'b000, ~freq_divider_output, 4'h0};
  assign pb_func_sel = {fn_ctrl_q[BPW_FN_FREQ], fn_ctrl_q[BPW_FN_PWM], 4'h0};
  assign pb_func_val = {freq_divider_output, pwm_in, 4'h0};

  wire [7:0] pa_val = (pa_func_sel & pa_func_val) | (~pa_func_sel & pa_data_q); // R12 R13
  wire [5:0] pb_val = (pb_func_sel & pb_func_val) | (~pb_func_sel & pb_data_q); // R12 R13
  wire [7:0] pa_oe_d;
  wire [7:0] pa_pu_d;
  wire [5:0] pb_pu_d;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pa
      if (gi == BPW_PA_OPEN_DRAIN) begin : g_od
        // NMOS-only pin: it can only pull low, high is left to the board
        assign pa_oe_d[gi] = ~pa_dir_q[gi] & ~pa_val[gi];
      end else begin : g_pp
        assign pa_oe_d[gi] = ~pa_dir_q[gi]; // R07
      end
      assign pa_pu_d[gi] = pa_dir_q[gi] & pa_pu_q[gi] & BPW_PA_PU_MASK[gi]; // R03 R08
    end
  endgenerate

  // Analog channels sit on port B bits 0..3
  assign pb_pu_d = pb_dir_q & pb_pu_q & ~{2'b00, analog_q}; // R03 R08 R14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out_q <= BPW_RST_PA_DATA;
      pa_oe_q <= 8'h00;
      pa_pu_out_q <= 8'h00;
      pb_out_q <= BPW_RST_PB_DATA;
      pb_oe_q <= 6'h00;
      pb_pu_out_q <= 6'h00;
    end else begin
      pa_out_q <= pa_val;
      pa_oe_q <= pa_oe_d;
      pa_pu_out_q <= pa_pu_d;
      pb_out_q <= pb_val;
      pb_oe_q <= ~pb_dir_q; // R07
      pb_pu_out_q <= pb_pu_d;
    end
  end

  // Shared inputs keep the normal port read path alongside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_q <= 1'b1;
      timer0_q <= 1'b0;
      timer1_q <= 1'b0;
    end else begin
      ext_irq_q <= pa_in[BPW_PA_EXT_IRQ] | ~pa_dir_q[BPW_PA_EXT_IRQ]; // R10
      timer0_q <= pa_in[BPW_PA_TIMER0] & pa_dir_q[BPW_PA_TIMER0] &
                  fn_ctrl_q[BPW_FN_T0_EXT]; // R11
      timer1_q <= pa_in[BPW_PA_TIMER1] & pa_dir_q[BPW_PA_TIMER1] &
                  fn_ctrl_q[BPW_FN_T1_EXT]; // R11
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pa_out = pa_out_q;
  assign pa_oe = pa_oe_q;
  assign pa_pullup = pa_pu_out_q;
  assign pb_out = pb_out_q;
  assign pb_oe = pb_oe_q;
  assign pb_pullup = pb_pu_out_q;
  assign ext_irq_pin = ext_irq_q;
  assign timer0_input_pin = timer0_q;
  assign timer1_input_pin = timer1_q;
  assign clk_stop = pd_q == BPW_HALT;
  assign wake_req = wake_req_q;
  assign irq = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_halt_write;
    wr_ok & hit_halt & pwdata[0] & (pd_q == BPW_RUN);
  endsequence

  sequence s_wake_edge;
    (pd_q == BPW_HALT) & |(pa_wake_q & pa_armed_q & ~pa_in);
  endsequence

  chk_read_live_pin: assert property (setup & ~pwrite & hit_pa_data |=> // R01
      prdata[7:0] == $past(pa_view)) else $error("port A read not the sampled view");
  chk_latch_hold: assert property (!(wr_ok & hit_pa_data) |=> // R02
      pa_data_q == $past(pa_data_q)) else $error("port A latch changed without a write");
  chk_pa7_no_pu: assert property (pa_pullup[BPW_PA_OPEN_DRAIN] == 1'b0) // R03
    else $error("port A bit 7 has a pull-up");
  chk_halt_entry: assert property (s_halt_write |=> clk_stop) // R04
    else $error("halt write did not stop the clock");
  chk_wake_exit: assert property (s_wake_edge |=> wake_req ##1 !clk_stop) // R05
    else $error("enabled falling edge did not wake");
  chk_wake_disabled: assert property ((pd_q == BPW_HALT) & (pa_wake_q == 8'h00) & // R06
      !wake_req |=> clk_stop) else $error("woke with all wake enables clear");
  chk_dir_drive: assert property (##1 pb_oe == ~$past(pb_dir_q)) // R07
    else $error("port B enable does not follow direction");
  chk_pu_input_only: assert property (pa_pullup[0] |-> // R08
      $past(pa_dir_q[0]) & $past(pa_pu_q[0]))
    else $error("pull-up on output or disabled pin");
  chk_out_read_latch: assert property (setup & ~pwrite & hit_pb_data & (pb_dir_q == 6'h00) // R09
      |=> prdata[5:0] == $past(pb_data_q)) else $error("output read not latch");
  chk_analog_no_pu: assert property (analog_q[0] |=> !pb_pullup[0]) // R14
    else $error("analog pin kept its pull-up");
  chk_pwm_gate: assert property (pb_dir_q[BPW_PB_PWM] |=> !pb_oe[BPW_PB_PWM]) // R13
    else $error("PWM pin driven while input");

  // Shared pins: input functions need input direction, output functions reach their pin only through output direction
  chk_ext_irq_input: assert property (pa_dir_q[BPW_PA_EXT_IRQ] |=> // R10
      ext_irq_pin == $past(pa_in[BPW_PA_EXT_IRQ]))
    else $error("external interrupt input does not follow its pin");
  chk_timer0_gate: assert property ( // R11
      (!fn_ctrl_q[BPW_FN_T0_EXT] | !pa_dir_q[BPW_PA_TIMER0]) |=> !timer0_input_pin)
    else $error("timer 0 input passed outside its mode");
  chk_timer1_gate: assert property ( // R11
      (!fn_ctrl_q[BPW_FN_T1_EXT] | !pa_dir_q[BPW_PA_TIMER1]) |=> !timer1_input_pin)
    else $error("timer 1 input passed outside its mode");
  chk_freq_gate: assert property (pa_dir_q[BPW_PA_FREQ_N] |=> !pa_oe[BPW_PA_FREQ_N]) // R12
    else $error("frequency pin driven while input");
  chk_freq_drive: assert property (fn_ctrl_q[BPW_FN_FREQ] & !pb_dir_q[BPW_PB_FREQ_P] |=> // R12
      pb_oe[BPW_PB_FREQ_P] & (pb_out[BPW_PB_FREQ_P] == $past(freq_divider_output)))
    else $error("frequency output not on its pin");
  chk_pwm_drive: assert property (fn_ctrl_q[BPW_FN_PWM] & !pb_dir_q[BPW_PB_PWM] |=> // R13
      pb_oe[BPW_PB_PWM] & (pb_out[BPW_PB_PWM] == $past(pwm_in)))
    else $error("PWM output not on its pin");

  // Direction, pull-up and power-down holding
  chk_pa_dir_drive: assert property (##1 pa_oe[6:0] == ~$past(pa_dir_q[6:0])) // R07
    else $error("port A enable does not follow direction");
  chk_od_release: assert property (pa_dir_q[BPW_PA_OPEN_DRAIN] |=> // R07
      !pa_oe[BPW_PA_OPEN_DRAIN]) else $error("open-drain pin driven while input");
  chk_pb_pu_input: assert property (pb_pullup[0] |-> $past(pb_dir_q[0])) // R03
    else $error("port B pull-up on an output pin");
  chk_halt_hold: assert property (clk_stop & !wake_req |=> clk_stop) // R04
    else $error("power-down left without a wake request");
  chk_wake_async: assert property (s_wake_edge |-> wake_req) // R17
    else $error("wake request not raised by the edge itself");
endmodule

// File: dv/bpw_board.sv
// Board model: switches, weak pull-ups and open pins around both ports
`timescale 1ns/1ps
module bpw_board (
  input wire logic pclk,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pullup,
  input wire logic [5:0] pb_out,
  input wire logic [5:0] pb_oe,
  input wire logic [5:0] pb_pullup,
  input wire logic [13:0] sw_en,
  input wire logic [13:0] sw_val,
  output logic [7:0] pa_pin,
  output logic [5:0] pb_pin
);
  logic [13:0] float_q = 14'h0000;
  logic [13:0] out_w;
  logic [13:0] oe_w;
  logic [13:0] pu_w;
  logic [13:0] pin_w;
  // An open pin flips every cycle so a read of it never matches by luck
  always @(posedge pclk) float_q <= ~float_q;
  assign out_w = {pb_out, pa_out};
  assign oe_w = {pb_oe, pa_oe};
  assign pu_w = {pb_pullup, pa_pullup};
  // Device drive beats a switch, a switch beats the weak pull-up
  assign pin_w = (oe_w & out_w) | (~oe_w & sw_en & sw_val)
    | (~oe_w & ~sw_en & pu_w) | (~oe_w & ~sw_en & ~pu_w & float_q);
  assign pa_pin = pin_w[7:0];
  assign pb_pin = pin_w[13:8];
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the two-port block with pull-ups and wake-up
`timescale 1ns/1ps
module tb_top;
  import bpw_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} bpw_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic freq = 1'b0;
  logic pwm_in = 1'b0;
  logic [13:0] sw_en = 14'h3fff;
  logic [13:0] sw_val = 14'h2a96;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, ext_irq_pin, timer0_input_pin, timer1_input_pin;
  logic clk_stop, wake_req, irq;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pullup;
  logic [5:0] pb_in, pb_out, pb_oe, pb_pullup;
  int mismatches = 0;
  int tests_run = 0;
  bpw_row_t rows[7] = '{'{BPW_OFF_PA_WAKE, 32'ha5, 32'ha5, 1'b0},
    '{BPW_OFF_PA_PU, 32'hff, 32'h7f, 1'b0}, '{BPW_OFF_PB_PU, 32'hff, 32'h3f, 1'b0},
    '{BPW_OFF_PB_DIR, 32'h2a, 32'h2a, 1'b0}, '{BPW_OFF_PA_DIR, 32'h5a, 32'h5a, 1'b0},
    '{BPW_OFF_ANALOG, 32'hff, 32'h0f, 1'b0}, '{8'h30, 32'hff, 32'h0, 1'b1}};
  logic [7:0] rst_a[5] = '{BPW_OFF_PA_DIR, BPW_OFF_PB_DIR, BPW_OFF_PA_PU, BPW_OFF_PA_WAKE,
    BPW_OFF_PB_PU};
  logic [31:0] rst_e[5] = '{32'hff, 32'h3f, 32'h0, 32'h0, 32'h0};

  always #2.5 pclk = ~pclk;

  bpw_port bpw_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup(pa_pullup), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pullup(pb_pullup), .freq_divider_output(freq), .pwm_in(pwm_in),
    .ext_irq_pin(ext_irq_pin), .timer0_input_pin(timer0_input_pin),
    .timer1_input_pin(timer1_input_pin), .clk_stop(clk_stop), .wake_req(wake_req),
    .irq(irq));
  bpw_board bpw_board_i (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup(pa_pullup), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
    .sw_en(sw_en), .sw_val(sw_val), .pa_pin(pa_in), .pb_pin(pb_in));

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until pready is seen high; the answer is taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk("pa_out", 32'hff, pa_out);
    chk("pa_oe", 32'h0, {pb_oe, pa_oe});
    chk("pullups", 32'h0, {pb_pullup, pa_pullup});
    for (int i = 0; i < 5; i++) rdc("reset value", rst_a[i], rst_e[i]);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      rdc("row data", rows[i].a, rows[i].e);
      chk("row err", {31'h0, rows[i].err}, {31'h0, er});
    end
    for (int i = 0; i < 5; i++) apb(1'b1, rst_a[i], rst_e[i]);
    apb(1'b1, BPW_OFF_ANALOG, 32'h0);
    rdc("pin read", BPW_OFF_PA_DATA, 32'h96);
    @(posedge pclk);
    sw_val[7:0] <= 8'h69;
    apb(1'b1, BPW_OFF_PA_DATA, 32'h3c);
    rdc("pin live", BPW_OFF_PA_DATA, 32'h69);
    apb(1'b1, BPW_OFF_PA_DIR, 32'hf0);
    apb(1'b0, BPW_OFF_PA_DIR, 32'h0);
    // Single-bit clear done as software would: whole byte read, modified, written
    apb(1'b1, BPW_OFF_PA_DIR, rd & ~32'h10);
    settle(2);
    chk("pa_oe rmw", 32'h1f, pa_oe);
    chk("pa_out low", 32'h1c, pa_out & 8'h1f);
    rdc("latch read", BPW_OFF_PA_DATA, 32'h7c);
    apb(1'b1, BPW_OFF_PB_DIR, 32'h0);
    settle(2);
    chk("pb first out", 32'h00000fff, {pb_oe, pb_out});
    apb(1'b1, BPW_OFF_PB_DATA, 32'h15);
    apb(1'b1, BPW_OFF_PB_DIR, 32'h3f);
    apb(1'b1, BPW_OFF_PB_DIR, 32'h0);
    settle(2);
    chk("pb latch", 32'h15, pb_out);
    rdc("pb latch read", BPW_OFF_PB_DATA, 32'h15);
    apb(1'b1, BPW_OFF_PA_PU, 32'hff);
    apb(1'b1, BPW_OFF_PA_DIR, 32'h0f);
    apb(1'b1, BPW_OFF_PB_PU, 32'h3f);
    apb(1'b1, BPW_OFF_PB_DIR, 32'h3f);
    apb(1'b1, BPW_OFF_ANALOG, 32'h5);
    settle(2);
    chk("pa_pullup", 32'h0f, pa_pullup);
    chk("pb_pullup", 32'h3a, pb_pullup);
    // Switches opened: input pins with a pull-up must read high
    @(posedge pclk);
    sw_en[7:0] <= 8'h00;
    rdc("pulled pins", BPW_OFF_PA_DATA, 32'h3f);
    sw_en <= 14'h3fff;
    apb(1'b1, BPW_OFF_PA_DIR, 32'hef);
    apb(1'b1, BPW_OFF_PB_DIR, 32'h0f);
    apb(1'b1, BPW_OFF_FN_CTRL, 32'h3);
    for (int f = 0; f < 2; f++) begin
      @(posedge pclk);
      freq <= f[0];
      pwm_in <= f[0];
      settle(2);
      chk("fn out", {29'h0, f[0], f[0], ~f[0]}, {pb_out[5:4], pa_out[4]});
      chk("fn oe", 32'h31, {pb_oe[5:4], pa_oe[7:4]});
    end
    apb(1'b1, BPW_OFF_PB_DIR, 32'h3f);
    apb(1'b1, BPW_OFF_PA_DIR, 32'hff);
    settle(2);
    chk("fn off", 32'h0, {pb_oe, pa_oe});
    apb(1'b1, BPW_OFF_FN_CTRL, 32'hc);
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      sw_val[7:0] <= v[0] ? 8'h69 : 8'h96;
      settle(2);
      chk("shared in", {29'h0, {3{v[0]}}},
        {timer1_input_pin, timer0_input_pin, ext_irq_pin});
      rdc("shared read", BPW_OFF_PA_DATA, v[0] ? 32'h69 : 32'h96);
    end
    apb(1'b1, BPW_OFF_FN_CTRL, 32'h0);
    settle(2);
    chk("timer gated", 32'h0, {timer1_input_pin, timer0_input_pin});
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, BPW_OFF_IRQ_MASK, m[0] ? 32'h2 : 32'h0);
      @(posedge pclk);
      sw_val[7:0] <= 8'h61;
      settle(3);
      chk("ext irq", {31'h0, m[0]}, {31'h0, irq});
      rdc("irq status", BPW_OFF_IRQ_STAT, 32'h2);
      apb(1'b1, BPW_OFF_IRQ_STAT, 32'h2);
      @(posedge pclk);
      sw_val[7:0] <= 8'h6d;
      settle(3);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    apb(1'b1, BPW_OFF_IRQ_MASK, 32'h1);
    apb(1'b1, BPW_OFF_PA_WAKE, 32'h04);
    apb(1'b1, BPW_OFF_HALT, 32'h1);
    settle(1);
    chk("halted", 32'h1, {31'h0, clk_stop});
    @(posedge pclk);
    sw_val[7:0] <= 8'h6c;
    settle(3);
    chk("no wake", 32'h1, {wake_req, clk_stop});
    @(posedge pclk);
    sw_val[7:0] <= 8'h68;
    #1;
    chk("wake async", 32'h1, {31'h0, wake_req});
    settle(1);
    chk("woken", 32'h0, {31'h0, clk_stop});
    settle(2);
    chk("wake irq", 32'h1, {31'h0, irq});
    apb(1'b1, BPW_OFF_IRQ_STAT, 32'h1);
    settle(3);
    chk("wake clear", 32'h0, {wake_req, irq});
    conclude();
  end
endmodule
